// ### common/vcd_pkg.sv
// Shared constants and types for the verify command decoder and its host end
package vcd_pkg;
  // ==========================================================
  // Opcodes and qualifiers
  localparam logic [7:0] OPC_V12 = 8'hAF;
  localparam logic [7:0] OPC_V16 = 8'h8F;
  localparam logic [7:0] OPC_V32 = 8'h7F;
  localparam logic [7:0] ADD_LEN_V32 = 8'h18;
  localparam logic [15:0] SVC_V32 = 16'h000A;
  localparam logic [2:0] PTYPE_2 = 3'h1;
  // ==========================================================
  // Descriptor lengths and byte positions
  localparam logic [5:0] LEN_V12 = 6'h0C;
  localparam logic [5:0] LEN_V16 = 6'h10;
  localparam logic [5:0] LEN_V32 = 6'h20;
  localparam int B_FLAGS = 1;
  localparam int B_LBA_SHORT = 2;
  localparam int B_VLEN_12 = 6;
  localparam int B_VLEN_16 = 10;
  localparam int B_CTL_12 = 11;
  localparam int B_CTL_16 = 15;
  localparam int B_ADDLEN = 7;
  localparam int B_SVC = 8;
  localparam int B_FLAGS_32 = 10;
  localparam int B_LBA_32 = 12;
  localparam int B_REF_32 = 20;
  localparam int B_APP_32 = 24;
  localparam int B_MASK_32 = 26;
  localparam int B_VLEN_32 = 28;
  // ==========================================================
  // Flag byte fields
  localparam int F_PSEL_HI = 7;
  localparam int F_PSEL_LO = 5;
  localparam int F_DPO = 4;
  localparam int F_FUA = 3;
  localparam int F_BC_HI = 2;
  localparam int F_BC_LO = 1;
  localparam logic [2:0] PSEL_ALL = 3'h0;
  localparam logic [2:0] PSEL_ALL_B = 3'h1;
  localparam logic [2:0] PSEL_NO_GUARD = 3'h2;
  localparam logic [2:0] PSEL_NONE = 3'h3;
  localparam logic [2:0] PSEL_GUARD = 3'h4;
  localparam logic [1:0] BC_MEDIA = 2'h0;
  localparam logic [1:0] BC_UNDEF = 2'h2;
  // ==========================================================
  // Outcome of a command
  typedef enum logic [2:0] {
    RSN_NONE = 3'h0,
    RSN_BAD_OPCODE = 3'h1,
    RSN_BAD_FIELD = 3'h2,
    RSN_GUARD = 3'h3,
    RSN_APP_TAG = 3'h4,
    RSN_REF_TAG = 3'h5,
    RSN_MISCOMPARE = 3'h6
  } vcd_reason_e;
  typedef enum logic [1:0] {
    FORM_NONE = 2'h0,
    FORM_V12 = 2'h1,
    FORM_V16 = 2'h2,
    FORM_V32 = 2'h3
  } vcd_form_e;
  typedef enum logic [3:0] {
    ST_RECV = 4'h1,
    ST_DEC = 4'h2,
    ST_EXEC = 4'h4,
    ST_RESP = 4'h8
  } vcd_state_e;
  // ==========================================================
  // Host register map, byte addresses
  localparam logic [7:0] A_CDB0 = 8'h00;
  localparam logic [7:0] A_CDB7 = 8'h1C;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_CHECK = 2;
  localparam int S_RSN_LO = 4;
  localparam int S_RSN_HI = 6;
endpackage : vcd_pkg

// ### common/vcd_link_if.sv
// Byte link between initiator end and command decoder end
interface vcd_link_if;
  logic cdb_valid;
  logic [7:0] cdb_byte;
  logic cdb_last;
  logic cdb_ready;
  logic rsp_valid;
  logic rsp_check;
  vcd_pkg::vcd_reason_e rsp_reason;
  modport dev (
    input cdb_valid, cdb_byte, cdb_last,
    output cdb_ready, rsp_valid, rsp_check, rsp_reason
  );
  modport host (
    output cdb_valid, cdb_byte, cdb_last,
    input cdb_ready, rsp_valid, rsp_check, rsp_reason
  );
endinterface : vcd_link_if

// ### verilog/vcd_device.sv
// Verify command decoder: descriptor intake, decode, protection checks
module vcd_device #(
  parameter int MAX_CDB = 32
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  vcd_link_if.dev LINK,
  input wire logic I_PROTECTION_ENABLED,
  input wire logic [2:0] I_PROT_TYPE,
  input wire logic I_APP_TAG_OWNER,
  input wire logic I_PI_VALID,
  input wire logic I_PI_GUARD_ERR,
  input wire logic [31:0] I_PI_REF,
  input wire logic [15:0] I_PI_APP,
  input wire logic I_MISCOMPARE,
  output logic O_CMD_START,
  output vcd_pkg::vcd_form_e O_FORM,
  output logic [63:0] O_LBA,
  output logic [31:0] O_VER_LEN,
  output logic [2:0] O_VERIFY_PROTECT_CHECK_SEL,
  output logic O_CACHE_LOW_PRIORITY_HINT,
  output logic O_FORCE_MEDIA_ACCESS,
  output logic [1:0] O_BYTE_COMPARE_MODE,
  output logic [7:0] O_CONTROL,
  output logic O_CHK_GUARD,
  output logic O_CHK_APP,
  output logic O_CHK_REF,
  output logic O_BUSY
);
  // ==========================================================
  // Descriptor store
  logic [7:0] cdb_mem [0:MAX_CDB-1];
  logic [5:0] cnt_reg;
  vcd_pkg::vcd_state_e state_reg;
  vcd_pkg::vcd_state_e state_next;
  logic [31:0] blk_reg;
  logic first_reg;
  logic [31:0] ref_exp_reg;
  logic [15:0] app_exp_reg;
  logic [15:0] app_mask_reg;
  vcd_pkg::vcd_reason_e rsn_reg;
  vcd_pkg::vcd_reason_e rsn_next;

  // Big-endian assembly, used for every multi-byte field
  function automatic logic [31:0] be32(input int pos);
    be32 = {cdb_mem[pos], cdb_mem[pos+1], cdb_mem[pos+2], cdb_mem[pos+3]};
  endfunction : be32

  function automatic logic [15:0] be16(input int pos);
    be16 = {cdb_mem[pos], cdb_mem[pos+1]};
  endfunction : be16

  // ==========================================================
  // Form decode
  wire logic [7:0] opc = cdb_mem[0];
  wire logic is12 = (opc == vcd_pkg::OPC_V12) && (cnt_reg == vcd_pkg::LEN_V12);
  wire logic is16 = (opc == vcd_pkg::OPC_V16) && (cnt_reg == vcd_pkg::LEN_V16);
  wire logic is32_op = (opc == vcd_pkg::OPC_V32) && (cnt_reg == vcd_pkg::LEN_V32)
    && (cdb_mem[vcd_pkg::B_ADDLEN] == vcd_pkg::ADD_LEN_V32);
  wire logic is32 = is32_op && (be16(vcd_pkg::B_SVC) == vcd_pkg::SVC_V32);
  wire logic type2_ok = I_PROTECTION_ENABLED && (I_PROT_TYPE == vcd_pkg::PTYPE_2);

  // Flags byte: byte 1 for short forms, byte 10 for the long one
  wire logic [7:0] flags = is32 ? cdb_mem[vcd_pkg::B_FLAGS_32]
    : cdb_mem[vcd_pkg::B_FLAGS];
  wire logic [2:0] psel = flags[vcd_pkg::F_PSEL_HI:vcd_pkg::F_PSEL_LO];
  wire logic [1:0] bcmp = flags[vcd_pkg::F_BC_HI:vcd_pkg::F_BC_LO];
  wire logic force_media_access = is12 && flags[vcd_pkg::F_FUA];

  wire logic [63:0] lba = is32 ? {be32(vcd_pkg::B_LBA_32), be32(vcd_pkg::B_LBA_32 + 4)}
    : is16 ? {be32(vcd_pkg::B_LBA_SHORT), be32(vcd_pkg::B_LBA_SHORT + 4)}
    : {32'h0000_0000, be32(vcd_pkg::B_LBA_SHORT)};
  wire logic [31:0] vlen = is32 ? be32(vcd_pkg::B_VLEN_32)
    : is16 ? be32(vcd_pkg::B_VLEN_16)
    : be32(vcd_pkg::B_VLEN_12);
  wire logic [7:0] ctl = is32 ? cdb_mem[vcd_pkg::B_FLAGS]
    : is16 ? cdb_mem[vcd_pkg::B_CTL_16] : cdb_mem[vcd_pkg::B_CTL_12];

  // Unknown forms and long form off type 2 are both opcode errors
  wire logic bad_opc = !(is12 || is16 || is32) || (is32 && !type2_ok);
  wire logic bad_field = (psel > vcd_pkg::PSEL_GUARD)
    || (!I_PROTECTION_ENABLED && psel != vcd_pkg::PSEL_ALL)
    || (bcmp == vcd_pkg::BC_UNDEF);

  // Check enables follow the protection selection table
  wire logic int_chk = (bcmp == vcd_pkg::BC_MEDIA) || (psel == vcd_pkg::PSEL_ALL);
  wire logic sel_gd = (psel == vcd_pkg::PSEL_ALL) || (psel == vcd_pkg::PSEL_ALL_B)
    || (psel == vcd_pkg::PSEL_GUARD);
  wire logic sel_tag = (psel == vcd_pkg::PSEL_ALL) || (psel == vcd_pkg::PSEL_ALL_B)
    || (psel == vcd_pkg::PSEL_NO_GUARD);
  wire logic en_guard = I_PROTECTION_ENABLED && int_chk && sel_gd;
  wire logic en_ref = I_PROTECTION_ENABLED && int_chk && sel_tag;
  wire logic en_app = en_ref && is32 && I_APP_TAG_OWNER;

  // ==========================================================
  // Per-block checks while executing
  wire logic app_bad = |((I_PI_APP ^ app_exp_reg) & app_mask_reg);
  wire logic ref_bad = first_reg && (I_PI_REF != ref_exp_reg);
  wire logic last_blk = (blk_reg + 32'h0000_0001) == O_VER_LEN;
  wire logic take = LINK.cdb_valid && LINK.cdb_ready;

  // Guard outranks tags, tags outrank the data compare
  always_comb begin
    rsn_next = rsn_reg;
    state_next = state_reg;
    unique case (state_reg)
      vcd_pkg::ST_RECV: begin
        if (take && LINK.cdb_last) begin
          state_next = vcd_pkg::ST_DEC;
        end
      end
      vcd_pkg::ST_DEC: begin
        if (bad_opc) begin
          rsn_next = vcd_pkg::RSN_BAD_OPCODE;
          state_next = vcd_pkg::ST_RESP;
        end else if (bad_field) begin
          rsn_next = vcd_pkg::RSN_BAD_FIELD;
          state_next = vcd_pkg::ST_RESP;
        end else if (vlen == 32'h0000_0000) begin
          rsn_next = vcd_pkg::RSN_NONE;
          state_next = vcd_pkg::ST_RESP;
        end else begin
          rsn_next = vcd_pkg::RSN_NONE;
          state_next = vcd_pkg::ST_EXEC;
        end
      end
      vcd_pkg::ST_EXEC: begin
        if (I_PI_VALID) begin
          if (O_CHK_GUARD && I_PI_GUARD_ERR) begin
            rsn_next = vcd_pkg::RSN_GUARD;
          end else if (O_CHK_APP && app_bad) begin
            rsn_next = vcd_pkg::RSN_APP_TAG;
          end else if (O_CHK_REF && ref_bad) begin
            rsn_next = vcd_pkg::RSN_REF_TAG;
          end else if ((O_BYTE_COMPARE_MODE != vcd_pkg::BC_MEDIA) && I_MISCOMPARE) begin
            rsn_next = vcd_pkg::RSN_MISCOMPARE;
          end
          if (rsn_next != vcd_pkg::RSN_NONE || last_blk) begin
            state_next = vcd_pkg::ST_RESP;
          end
        end
      end
      vcd_pkg::ST_RESP: begin
        state_next = vcd_pkg::ST_RECV;
      end
      default: begin
        state_next = vcd_pkg::ST_RECV;
      end
    endcase
  end

  // ==========================================================
  // Sequencer and byte intake
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= vcd_pkg::ST_RECV;
      rsn_reg <= vcd_pkg::RSN_NONE;
      cnt_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      rsn_reg <= rsn_next;
      if (state_reg == vcd_pkg::ST_RESP) begin
        cnt_reg <= 6'h00;
      end else if (take && cnt_reg != vcd_pkg::LEN_V32) begin
        cnt_reg <= cnt_reg + 6'h01; // Extra bytes beyond 32 are dropped
      end
    end
  end

  // Storage has no reset; stale bytes reach only the app tag registers, which only the long form checks
  always_ff @(posedge I_CLK) begin
    if (take && cnt_reg != vcd_pkg::LEN_V32) begin
      cdb_mem[cnt_reg[4:0]] <= LINK.cdb_byte;
    end
  end

  // ==========================================================
  // Decoded fields, latched when the descriptor passes decode, zero-length ones too
  wire logic accept = (state_reg == vcd_pkg::ST_DEC) && (state_next == vcd_pkg::ST_EXEC);
  wire logic decoded = (state_reg == vcd_pkg::ST_DEC) && !bad_opc && !bad_field;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FORM <= vcd_pkg::FORM_NONE;
      O_LBA <= 64'h0000_0000_0000_0000;
      O_VER_LEN <= 32'h0000_0000;
      O_VERIFY_PROTECT_CHECK_SEL <= 3'h0;
      O_CACHE_LOW_PRIORITY_HINT <= 1'h0;
      O_FORCE_MEDIA_ACCESS <= 1'h0;
      O_BYTE_COMPARE_MODE <= 2'h0;
      O_CONTROL <= 8'h00;
      O_CHK_GUARD <= 1'h0;
      O_CHK_APP <= 1'h0;
      O_CHK_REF <= 1'h0;
      ref_exp_reg <= 32'h0000_0000;
      app_exp_reg <= 16'h0000;
      app_mask_reg <= 16'h0000;
    end else if (decoded) begin
      O_FORM <= is32 ? vcd_pkg::FORM_V32 : is16 ? vcd_pkg::FORM_V16 : vcd_pkg::FORM_V12;
      O_LBA <= lba;
      O_VER_LEN <= vlen;
      O_VERIFY_PROTECT_CHECK_SEL <= psel;
      O_CACHE_LOW_PRIORITY_HINT <= flags[vcd_pkg::F_DPO];
      O_FORCE_MEDIA_ACCESS <= force_media_access;
      O_BYTE_COMPARE_MODE <= bcmp;
      O_CONTROL <= ctl;
      O_CHK_GUARD <= en_guard;
      O_CHK_APP <= en_app;
      O_CHK_REF <= en_ref;
      ref_exp_reg <= is32 ? be32(vcd_pkg::B_REF_32) : lba[31:0];
      app_exp_reg <= be16(vcd_pkg::B_APP_32);
      app_mask_reg <= be16(vcd_pkg::B_MASK_32);
    end
  end

  // ==========================================================
  // Block progress, status strobes and link outputs
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      blk_reg <= 32'h0000_0000;
      first_reg <= 1'h0;
      O_CMD_START <= 1'h0;
      O_BUSY <= 1'h0;
      LINK.cdb_ready <= 1'h0;
      LINK.rsp_valid <= 1'h0;
      LINK.rsp_check <= 1'h0;
      LINK.rsp_reason <= vcd_pkg::RSN_NONE;
    end else begin
      O_CMD_START <= accept;
      O_BUSY <= state_next == vcd_pkg::ST_EXEC;
      if (accept) begin
        blk_reg <= 32'h0000_0000;
        first_reg <= 1'h1;
      end else if (state_reg == vcd_pkg::ST_EXEC && I_PI_VALID) begin
        blk_reg <= blk_reg + 32'h0000_0001;
        first_reg <= 1'h0; // Only the first block carries the initial tag
      end
      // Ready drops right after the last byte so nothing overlaps a command
      LINK.cdb_ready <= (state_next == vcd_pkg::ST_RECV) && !(take && LINK.cdb_last);
      LINK.rsp_valid <= state_next == vcd_pkg::ST_RESP;
      if (state_next == vcd_pkg::ST_RESP) begin
        LINK.rsp_check <= rsn_next != vcd_pkg::RSN_NONE;
        LINK.rsp_reason <= rsn_next;
      end
    end
  end
endmodule : vcd_device

// ### verilog/vcd_host.sv
// Initiator end: APB-programmed descriptor sender and status collector
module vcd_host (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  vcd_link_if.host LINK
);
  // ==========================================================
  // Registers and send state
  logic [31:0] cdb_mem [0:7];
  logic [5:0] len_reg;
  logic [5:0] idx_reg;
  logic busy_reg;
  logic done_reg;
  logic chk_reg;
  vcd_pkg::vcd_reason_e rsn_reg;

  // Byte k of the descriptor sits in word k/4, lane k%4
  function automatic logic [7:0] byte_at(input logic [5:0] k);
    logic [31:0] w;
    w = cdb_mem[k[4:2]];
    byte_at = w[{k[1:0], 3'h0} +: 8];
  endfunction : byte_at

  // ==========================================================
  // Address decode; one wait state gives registered read data
  wire logic hit_cdb = I_PADDR <= vcd_pkg::A_CDB7 && I_PADDR[1:0] == 2'h0;
  wire logic hit_ctl = I_PADDR == vcd_pkg::A_CTRL;
  wire logic hit_st = I_PADDR == vcd_pkg::A_STAT;
  wire logic mapped = hit_cdb || hit_ctl || hit_st;
  wire logic acc = I_PSEL && I_PENABLE && !O_PREADY;
  wire logic wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && mapped;
  wire logic start = wr && hit_ctl && !busy_reg && I_PWDATA[5:0] != 6'h00;
  wire logic [31:0] stat = {25'h000_0000, rsn_reg, 1'h0, chk_reg, done_reg, busy_reg};
  wire logic [31:0] rd = hit_cdb ? cdb_mem[I_PADDR[4:2]]
    : hit_ctl ? {26'h000_0000, len_reg} : hit_st ? stat : 32'h0000_0000;
  wire logic hs = LINK.cdb_valid && LINK.cdb_ready;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PREADY <= 1'h0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'h0;
    end else begin
      O_PREADY <= acc;
      O_PRDATA <= acc && !I_PWRITE ? rd : 32'h0000_0000;
      O_PSLVERR <= acc && !mapped;
    end
  end

  // Descriptor words are frozen while a command is in flight
  always_ff @(posedge I_CLK) begin
    if (wr && hit_cdb && !busy_reg) begin
      cdb_mem[I_PADDR[4:2]] <= I_PWDATA;
    end
  end

  // ==========================================================
  // Byte sender and response capture
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      len_reg <= 6'h00;
      idx_reg <= 6'h00;
      busy_reg <= 1'h0;
      done_reg <= 1'h0;
      chk_reg <= 1'h0;
      rsn_reg <= vcd_pkg::RSN_NONE;
      LINK.cdb_valid <= 1'h0;
      LINK.cdb_byte <= 8'h00;
      LINK.cdb_last <= 1'h0;
    end else begin
      if (start) begin
        len_reg <= I_PWDATA[5:0];
        idx_reg <= 6'h00;
        busy_reg <= 1'h1;
        LINK.cdb_valid <= 1'h1;
        LINK.cdb_byte <= byte_at(6'h00);
        LINK.cdb_last <= I_PWDATA[5:0] == 6'h01;
      end else if (hs && LINK.cdb_last) begin
        LINK.cdb_valid <= 1'h0;
        LINK.cdb_last <= 1'h0;
      end else if (hs) begin
        idx_reg <= idx_reg + 6'h01;
        LINK.cdb_byte <= byte_at(idx_reg + 6'h01);
        LINK.cdb_last <= idx_reg + 6'h02 == len_reg;
      end
      // A response in the clearing cycle still sets done
      if (busy_reg && LINK.rsp_valid) begin
        busy_reg <= 1'h0;
        done_reg <= 1'h1;
        chk_reg <= LINK.rsp_check;
        rsn_reg <= LINK.rsp_reason;
      end else if (wr && hit_st && I_PWDATA[vcd_pkg::S_DONE]) begin
        done_reg <= 1'h0;
      end
    end
  end
endmodule : vcd_host

// ### sim/vcd_link_asserts.sv
// Concurrent checks on the byte link between the initiator end and the decoder end
module vcd_link_asserts (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_byte,
  input wire logic cdb_last,
  input wire logic cdb_ready,
  input wire logic rsp_valid,
  input wire logic rsp_check,
  input wire vcd_pkg::vcd_reason_e rsp_reason
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================
  // Descriptor tracking
  logic [5:0] cnt_reg;
  logic [7:0] op_reg;
  logic [7:0] len_reg;
  logic [15:0] svc_reg;
  // Opcode taken live on byte 0, so a one-byte descriptor is judged too
  wire take = cdb_valid && cdb_ready;
  wire [7:0] op_w = (cnt_reg == 6'h00) ? cdb_byte : op_reg;
  wire [5:0] total_w = cnt_reg + 6'h01;
  wire bad_len_w = (op_w == vcd_pkg::OPC_V12) ? (total_w != vcd_pkg::LEN_V12) :
    (op_w == vcd_pkg::OPC_V16) ? (total_w != vcd_pkg::LEN_V16) :
    (op_w == vcd_pkg::OPC_V32) ? (total_w != vcd_pkg::LEN_V32) : 1'h1;
  wire bad_qual_w = (op_w == vcd_pkg::OPC_V32) && (total_w == vcd_pkg::LEN_V32) &&
    (len_reg != vcd_pkg::ADD_LEN_V32 || svc_reg != vcd_pkg::SVC_V32);
  // Byte counter restarts after the final byte
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_reg <= 6'h00;
    end else if (take) begin
      cnt_reg <= cdb_last ? 6'h00 : total_w;
    end
  end
  // Qualifier bytes; no reset, they are only read once captured
  always_ff @(posedge I_CLK) begin
    if (take && cnt_reg == 6'h00) op_reg <= cdb_byte;
    if (take && cnt_reg == 6'h07) len_reg <= cdb_byte;
    if (take && cnt_reg == 6'h08) svc_reg[15:8] <= cdb_byte;
    if (take && cnt_reg == 6'h09) svc_reg[7:0] <= cdb_byte;
  end
  // ======================================
  // Properties
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  sequence s_last_taken;
    cdb_valid && cdb_ready && cdb_last;
  endsequence
  sequence s_opcode_refused;
    rsp_valid && rsp_check && rsp_reason == vcd_pkg::RSN_BAD_OPCODE;
  endsequence
  a_byte_held: assert property (cdb_valid && !cdb_ready |=> cdb_valid && $stable(cdb_byte))
    else $error("descriptor byte changed before acceptance");
  a_ready_drop: assert property (s_last_taken |=> !cdb_ready)
    else $error("ready still high after final byte");
  a_len_refused: assert property (s_last_taken ##0 bad_len_w |-> ##2 s_opcode_refused)
    else $error("wrong length or opcode not refused");
  a_qual_refused: assert property (s_last_taken ##0 bad_qual_w |-> ##2 s_opcode_refused)
    else $error("bad long-form qualifier not refused");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_ready_after_rsp: assert property (rsp_valid |-> !cdb_ready ##1 cdb_ready)
    else $error("ready not restored after response");
  // Status moves only at the edge that raises the response pulse
  a_status_held: assert property (!rsp_valid |-> $stable(rsp_check) && $stable(rsp_reason))
    else $error("status changed without a response");
  a_check_agrees: assert property (rsp_valid |-> rsp_check == (rsp_reason != 3'h0))
    else $error("check flag and reason disagree");
endmodule : vcd_link_asserts

// ### sim/vcd_tb.sv
// Self-checking bench: APB-driven initiator end facing the decoder end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================
  // Stimulus, observation and bookkeeping
  logic I_CLK;
  logic I_RST_B;
  logic psel, pen, pwr, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pi_ref;
  logic protection_enabled, owner, pi_valid, pi_guard, pi_mis;
  logic [2:0] ptype, sel;
  logic [15:0] pi_app;
  logic start, hint, force_media_access, busy, chk_g, chk_a, chk_r;
  vcd_pkg::vcd_form_e form;
  logic [63:0] lba;
  logic [31:0] vlen;
  logic [1:0] bcm;
  logic [7:0] ctl;
  logic [7:0] cdb [32];
  int error_cnt = 0;
  int checks_done = 0;
  int starts = 0;
  vcd_link_if link ();
  // ======================================
  // The two ends and the link checker
  vcd_host i_vcd_host (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link));
  vcd_device i_vcd_device (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .LINK(link),
    .I_PROTECTION_ENABLED(protection_enabled), .I_PROT_TYPE(ptype), .I_APP_TAG_OWNER(owner),
    .I_PI_VALID(pi_valid), .I_PI_GUARD_ERR(pi_guard), .I_PI_REF(pi_ref), .I_PI_APP(pi_app),
    .I_MISCOMPARE(pi_mis), .O_CMD_START(start), .O_FORM(form), .O_LBA(lba),
    .O_VER_LEN(vlen), .O_VERIFY_PROTECT_CHECK_SEL(sel), .O_CACHE_LOW_PRIORITY_HINT(hint),
    .O_FORCE_MEDIA_ACCESS(force_media_access), .O_BYTE_COMPARE_MODE(bcm), .O_CONTROL(ctl),
    .O_CHK_GUARD(chk_g), .O_CHK_APP(chk_a), .O_CHK_REF(chk_r), .O_BUSY(busy));
  vcd_link_asserts i_vcd_link_asserts (.I_CLK(I_CLK), .I_RST_B(I_RST_B),
    .cdb_valid(link.cdb_valid), .cdb_byte(link.cdb_byte), .cdb_last(link.cdb_last),
    .cdb_ready(link.cdb_ready), .rsp_valid(link.rsp_valid), .rsp_check(link.rsp_check),
    .rsp_reason(link.rsp_reason));
  // ======================================
  // Clock, start counter and hang guard
  initial begin
    I_CLK = 1'h0;
    forever #25 I_CLK = ~I_CLK;
  end
  // Counting starts shows refused and zero-length commands never executed
  always @(posedge I_CLK) begin
    if (start === 1'h1) starts++;
  end
  // The run needs about a thousand cycles; this many means a hang
  initial begin
    repeat (20000) @(posedge I_CLK);
    error_cnt++;
    end_of_test();
  end
  // ======================================
  // Shared tasks
  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held from setup until pready is sampled high, released at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge I_CLK);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge I_CLK);
    pen <= 1'h1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge I_CLK);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task automatic base(input logic [7:0] op);
    foreach (cdb[i]) cdb[i] = 8'h00;
    cdb[0] = op;
  endtask : base
  // Multi-byte fields go most significant byte first
  task automatic put(input int idx, input int nb, input logic [63:0] v);
    for (int i = 0; i < nb; i++) cdb[idx + i] = v[8 * (nb - 1 - i) +: 8];
  endtask : put
  task automatic send(input logic [5:0] n);
    logic [31:0] q;
    logic e;
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, vcd_pkg::A_CDB0 + 8'(4 * k),
        {cdb[4 * k + 3], cdb[4 * k + 2], cdb[4 * k + 1], cdb[4 * k]}, q, e);
    end
    apb(1'h1, vcd_pkg::A_CTRL, {26'h000_0000, n}, q, e);
  endtask : send
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(negedge I_CLK);
      n++;
    end while (start !== 1'h1 && n < 300);
    chk(start, 1'h1);
  endtask : wait_start
  task automatic feed(input logic [31:0] r, input logic [15:0] a, input logic g, input logic m);
    @(posedge I_CLK);
    pi_valid <= 1'h1;
    pi_ref <= r;
    pi_app <= a;
    pi_guard <= g;
    pi_mis <= m;
    @(posedge I_CLK);
    pi_valid <= 1'h0;
  endtask : feed
  // Polls status until done, compares it, then clears done
  task automatic finish_cmd(input logic ck, input vcd_pkg::vcd_reason_e rsn);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'h0, vcd_pkg::A_STAT, 32'h0000_0000, q, e);
      n++;
    end while (q[1] !== 1'h1 && n < 100);
    chk(q[6:0], {rsn, 1'h0, ck, 2'h2});
    apb(1'h1, vcd_pkg::A_STAT, 32'h0000_0002, q, e);
  endtask : finish_cmd
  task automatic reject(input logic [5:0] n, input logic ck, input vcd_pkg::vcd_reason_e rsn);
    int s;
    s = starts;
    send(n);
    finish_cmd(ck, rsn);
    chk(starts - s, 64'h0);
  endtask : reject
  task automatic v32();
    base(vcd_pkg::OPC_V32);
    put(7, 1, 64'h18);
    put(8, 2, 64'hA);
    put(10, 1, 64'h20);
    put(12, 8, 64'hA0B0_C0D0_E0F0_0102);
    put(20, 4, 64'hCAFE_F00D);
    put(24, 2, 64'h1234);
    put(26, 2, 64'hFF00);
    put(28, 4, 64'h3);
  endtask : v32
  // ======================================
  // Scenarios
  task automatic t_short12();
    base(vcd_pkg::OPC_V12);
    put(1, 1, 64'h1A);
    put(2, 4, 64'h1122_3344);
    put(6, 4, 64'h2);
    put(11, 1, 64'h3);
    send(6'h0C);
    wait_start();
    chk(form, vcd_pkg::FORM_V12);
    chk({vlen, lba[31:0]}, 64'h2_1122_3344);
    chk({busy, hint, force_media_access, bcm, ctl, sel}, 64'hE818);
    feed(32'h0000_0000, 16'h0000, 1'h0, 1'h0);
    feed(32'h0000_0000, 16'h0000, 1'h0, 1'h0);
    finish_cmd(1'h0, vcd_pkg::RSN_NONE);
  endtask : t_short12
  task automatic t_long16();
    base(vcd_pkg::OPC_V16);
    put(1, 1, 64'hA);
    put(2, 8, 64'h0102_0304_0506_0708);
    put(10, 4, 64'h5);
    put(15, 1, 64'h1);
    send(6'h10);
    wait_start();
    chk(form, vcd_pkg::FORM_V16);
    chk(lba, 64'h0102_0304_0506_0708);
    chk({vlen, busy, hint, force_media_access, bcm, ctl}, 64'hB101);
    feed(32'h0000_0000, 16'h0000, 1'h0, 1'h1);
    finish_cmd(1'h1, vcd_pkg::RSN_MISCOMPARE);
  endtask : t_long16
  // Block 1 carries the reference tag; block 3 breaks a masked-in app bit when a3=1334
  task automatic t_v32(input logic own, input logic [31:0] r, input logic [15:0] a3,
      input logic g, input logic ck, input vcd_pkg::vcd_reason_e rsn);
    protection_enabled <= 1'h1;
    ptype <= vcd_pkg::PTYPE_2;
    owner <= own;
    v32();
    send(6'h20);
    wait_start();
    chk(form, vcd_pkg::FORM_V32);
    chk(lba, 64'hA0B0_C0D0_E0F0_0102);
    chk(vlen, 64'h3);
    chk({sel, chk_g, chk_a, chk_r}, {3'h1, 1'h1, own, 1'h1});
    feed(r, 16'h12AB, g, 1'h0);
    feed(32'h0000_0000, 16'h1299, 1'h0, 1'h0);
    feed(32'h0000_0000, a3, 1'h0, 1'h0);
    finish_cmd(ck, rsn);
  endtask : t_v32
  task automatic t_refused();
    logic [31:0] q;
    logic e;
    ptype <= 3'h0;
    v32();
    reject(6'h20, 1'h1, vcd_pkg::RSN_BAD_OPCODE);
    ptype <= vcd_pkg::PTYPE_2;
    put(7, 1, 64'h17);
    reject(6'h20, 1'h1, vcd_pkg::RSN_BAD_OPCODE);
    v32();
    put(8, 2, 64'hB);
    reject(6'h20, 1'h1, vcd_pkg::RSN_BAD_OPCODE);
    base(vcd_pkg::OPC_V16);
    reject(6'h0C, 1'h1, vcd_pkg::RSN_BAD_OPCODE);
    for (int s = 5; s < 8; s++) begin
      base(vcd_pkg::OPC_V12);
      put(1, 1, 64'(s << 5));
      reject(6'h0C, 1'h1, vcd_pkg::RSN_BAD_FIELD);
    end
    base(vcd_pkg::OPC_V12);
    put(1, 1, 64'h4);
    reject(6'h0C, 1'h1, vcd_pkg::RSN_BAD_FIELD);
    base(vcd_pkg::OPC_V12);
    reject(6'h0C, 1'h0, vcd_pkg::RSN_NONE);
    apb(1'h0, 8'h40, 32'h0000_0000, q, e);
    chk({e, q}, 64'h1_0000_0000);
  endtask : t_refused
  // ======================================
  // Main sequence
  initial begin
    I_RST_B = 1'h0;
    {psel, pen, pwr, paddr, pwdata} = '0;
    {protection_enabled, owner, ptype, pi_valid, pi_guard, pi_mis, pi_ref, pi_app} = '0;
    repeat (12) @(posedge I_CLK);
    I_RST_B <= 1'h1;
    t_short12();
    t_long16();
    t_v32(1'h1, 32'hCAFE_F00D, 16'h1334, 1'h0, 1'h1, vcd_pkg::RSN_APP_TAG);
    t_v32(1'h0, 32'hCAFE_F00D, 16'h1334, 1'h0, 1'h0, vcd_pkg::RSN_NONE);
    t_v32(1'h1, 32'hCAFE_F00E, 16'h1234, 1'h0, 1'h1, vcd_pkg::RSN_REF_TAG);
    t_v32(1'h1, 32'hCAFE_F00D, 16'h1234, 1'h1, 1'h1, vcd_pkg::RSN_GUARD);
    t_refused();
    end_of_test();
  end
endmodule : testbench
